/* far_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module far_codec (
	input  wire logic        tx_clk,
	input  wire logic        tx_fs,
	input  wire logic        tx_data,
	input  wire logic        continuous,
	output logic             cap_stb,
	output logic [15:0]      cap_word,
	output logic             rx_clk,
	output logic             rx_fs,
	output logic             rx_data
);
	logic [15:0] sh;
	int          cnt;
	bit          framing;

	initial begin
		cap_stb = 1'b0;
		cap_word = 16'h0000;
		rx_clk = 1'b0;
		rx_fs = 1'b0;
		rx_data = 1'b0;
		cnt = 0;
		framing = 1'b0;
	end

	// Sample mid-bit on the fall, since the port changes data on the rise
	always @(negedge tx_clk) begin
		if (tx_fs === 1'b1) begin
			sh = {15'h0000, tx_data};
			cnt = 1;
			framing = 1'b1;
		end else if (framing) begin
			sh = {sh[14:0], tx_data};
			cnt = cnt + 1;
		end
		if (framing && cnt == 16) begin
			cap_word = sh;
			cap_stb = ~cap_stb;
			cnt = 0;
			framing = continuous;
		end
	end

	// Bit clock pulses once per bit of the word; data changes on the fall
	task automatic send_word(input logic [15:0] w, input logic sync);
		for (int i = 15; i >= 0; i--) begin
			rx_fs = sync && (i == 15);
			rx_data = w[i];
			#15 rx_clk = 1'b1;
			#15 rx_clk = 1'b0;
		end
	endtask

	// Released line must not keep showing the last bit
	task automatic line_idle(input int pulses);
		rx_fs = 1'b0;
		rx_data = ~rx_data;
		repeat (pulses) begin
			#15 rx_clk = 1'b1;
			#15 rx_clk = 1'b0;
		end
	endtask
endmodule // far_codec
`default_nettype wire

/* sync_queue.sv */
`timescale 1ns/1ps
`default_nettype none

package sync_serial_pkg;
	localparam int              WORD_W      = 16;
	localparam int              QUEUE_DEPTH = 4;
	localparam int              LVL_W       = 3;
	localparam logic [LVL_W-1:0] LVL_FULL   = 3'h4;
	localparam logic [3:0]      BIT_LAST    = 4'hf;
	localparam logic [3:0]      BIT_ONE     = 4'h1;
	localparam logic [3:0]      BIT_ZERO    = 4'h0;
	localparam logic [15:0]     WORD_RST    = 16'h0000;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b01,
		RX_SHIFT = 2'b10
	} rx_state_t;
endpackage

module sync_queue #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic                       clock,
	input  wire logic                       reset_n,
	input  wire logic                       clear,
	input  wire logic                       in_valid,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            in_ready,
	output logic                            out_valid,
	output logic [WIDTH-1:0]                out_data,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    nxt_wr_ptr;
	logic [PW-1:0]    rd_ptr_ff;
	logic [PW-1:0]    nxt_rd_ptr;
	logic [CW-1:0]    cnt_ff;
	logic [CW-1:0]    nxt_cnt;
	logic             in_ready_ff;
	logic             nxt_in_ready;
	logic             out_valid_ff;
	logic             nxt_out_valid;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready_ff;
	assign pop       = out_ready && out_valid_ff;
	assign in_ready  = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data  = mem[rd_ptr_ff];
	assign level     = cnt_ff;

	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_cnt    = cnt_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + PW'(1);
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + PW'(1);
		end
		if (push && !pop) begin
			nxt_cnt = cnt_ff + CW'(1);
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
		if (!reset_n || clear) begin
			nxt_wr_ptr = '0;
			nxt_rd_ptr = '0;
			nxt_cnt    = '0;
		end
		// Flags registered from the next count so both ports see flops
		// Refuse words while held in reset so none is accepted and lost
		nxt_in_ready  = (nxt_cnt != CW'(DEPTH)) && reset_n && !clear;
		nxt_out_valid = (nxt_cnt != '0);
	end

	always_ff @(posedge clock) begin
		wr_ptr_ff    <= nxt_wr_ptr;
		rd_ptr_ff    <= nxt_rd_ptr;
		cnt_ff       <= nxt_cnt;
		in_ready_ff  <= nxt_in_ready;
		out_valid_ff <= nxt_out_valid;
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end
endmodule // sync_queue

`default_nettype wire

/* sync_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four-word queue in each direction
// - Internal bit clock at half cpu rate
// - Fully static, no minimum bit rate
// - Continuous mode: back to back words
// - Burst mode: one word per sync
// - Transmit clock pin direction follows selection
// - Frame sync marks start, direction selectable
// - Shifter drives serial output on bit clock
// - Receive data enters shifter bit by bit
// - Queue levels raise transmit, receive interrupts
// - Words travel most significant bit first
// - Empty shifter loads oldest queued word
// - Reset bits low hold halves reset
module sync_serial_port
	import sync_serial_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              tx_reset_n_bit,
	input  wire logic              rx_reset_n_bit,
	input  wire logic              tx_clock_internal,
	input  wire logic              tx_fsync_internal,
	input  wire logic              continuous_mode,
	input  wire logic [1:0]        tx_irq_level,
	input  wire logic [1:0]        rx_irq_level,
	input  wire logic [WORD_W-1:0] tx_word,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	output logic [WORD_W-1:0]      rx_word,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic                   tx_queue_irq,
	output logic                   rx_queue_irq,
	output logic                   tx_complete,
	output logic                   rx_not_empty,
	output logic                   rx_overflow,
	input  wire logic              tx_bit_clock_in,
	output logic                   tx_bit_clock_out,
	output logic                   tx_bit_clock_oe,
	input  wire logic              tx_frame_sync_in,
	output logic                   tx_frame_sync_out,
	output logic                   tx_frame_sync_oe,
	output logic                   serial_data_out,
	input  wire logic              rx_bit_clock,
	input  wire logic              rx_frame_sync,
	input  wire logic              serial_data_in
);
	function automatic logic reaches(input logic [LVL_W-1:0] n,
		input logic [1:0] sel);
		reaches = (n >= ({1'b0, sel} + 3'h1));
	endfunction

	// Transmit side, cpu clock
	logic              tx_rst;
	logic [1:0]        pin_meta_ff;
	logic [1:0]        pin_sync_ff;
	logic              tclk_prev_ff;
	tx_state_t         tx_state_ff;
	tx_state_t         nxt_tx_state;
	logic [WORD_W-1:0] tx_shifter_ff;
	logic [WORD_W-1:0] nxt_tx_shifter;
	logic [3:0]        tx_cnt_ff;
	logic [3:0]        nxt_tx_cnt;
	logic              tdata_ff;
	logic              nxt_tdata;
	logic              tclk_ff;
	logic              nxt_tclk;
	logic              tclk_oe_ff;
	logic              nxt_tclk_oe;
	logic              tfs_ff;
	logic              nxt_tfs;
	logic              tfs_oe_ff;
	logic              nxt_tfs_oe;
	logic              tx_irq_ff;
	logic              nxt_tx_irq;
	logic              tx_busy_ff;
	logic              nxt_tx_busy;
	logic              tx_tick;
	logic              fs_ok;
	logic              tx_start;
	logic              tx_chain;
	logic              tx_load;
	logic              tx_q_valid;
	logic [WORD_W-1:0] tx_q_word;
	logic              tx_q_msb;
	logic [LVL_W-1:0]  tx_q_level;
	logic [LVL_W-1:0]  tx_q_space;

	assign tx_rst = !reset_n || !tx_reset_n_bit;

	sync_queue #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) u_tx_queue (
		.clock     (clock),
		.reset_n   (reset_n),
		.clear     (tx_rst),
		.in_valid  (tx_valid),
		.in_data   (tx_word),
		.in_ready  (tx_ready),
		.out_valid (tx_q_valid),
		.out_data  (tx_q_word),
		.out_ready (tx_load),
		.level     (tx_q_level)
	);

	// External clock and sync pins pass two flops before any use
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pin_meta_ff  <= 2'h0;
			pin_sync_ff  <= 2'h0;
			tclk_prev_ff <= 1'b0;
		end else begin
			pin_meta_ff  <= {tx_frame_sync_in, tx_bit_clock_in};
			pin_sync_ff  <= pin_meta_ff;
			tclk_prev_ff <= pin_sync_ff[0];
		end
	end

	// Edge driven only, so an external clock may run as slow as it likes
	assign tx_tick = tx_clock_internal ? !tclk_ff
		: (pin_sync_ff[0] && !tclk_prev_ff);
	assign fs_ok = tx_fsync_internal || pin_sync_ff[1];
	assign tx_start = tx_tick && (tx_state_ff == TX_IDLE) && tx_q_valid
		&& fs_ok && !tx_rst;
	assign tx_chain = tx_tick && (tx_state_ff == TX_SHIFT)
		&& (tx_cnt_ff == BIT_ZERO) && continuous_mode && tx_q_valid
		&& !tx_rst;
	assign tx_load    = tx_start || tx_chain;
	assign tx_q_msb   = tx_q_word[WORD_W-1];
	assign tx_q_space = LVL_FULL - tx_q_level;

	always_comb begin
		nxt_tx_state   = tx_state_ff;
		nxt_tx_shifter = tx_shifter_ff;
		nxt_tx_cnt     = tx_cnt_ff;
		nxt_tdata      = tdata_ff;
		nxt_tfs        = tfs_ff;
		nxt_tclk       = tx_clock_internal ? !tclk_ff : 1'b0;
		nxt_tclk_oe    = tx_clock_internal;
		nxt_tfs_oe     = tx_fsync_internal;
		nxt_tx_irq     = reaches(tx_q_space, tx_irq_level);
		nxt_tx_busy    = (tx_q_level != '0);
		if (tx_load) begin
			nxt_tx_state   = TX_SHIFT;
			nxt_tdata      = tx_q_msb;
			nxt_tx_shifter = {tx_q_word[WORD_W-2:0], 1'b0};
			nxt_tx_cnt     = BIT_LAST;
			nxt_tfs        = tx_start && tx_fsync_internal;
		end else if (tx_tick && (tx_state_ff == TX_SHIFT)) begin
			nxt_tfs = 1'b0;
			if (tx_cnt_ff != BIT_ZERO) begin
				nxt_tdata      = tx_shifter_ff[WORD_W-1];
				nxt_tx_shifter = {tx_shifter_ff[WORD_W-2:0], 1'b0};
				nxt_tx_cnt     = tx_cnt_ff - BIT_ONE;
			end else begin
				// Burst, or nothing queued: wait for the next sync
				nxt_tx_state = TX_IDLE;
				nxt_tdata    = 1'b0;
			end
		end
		if (tx_rst) begin
			nxt_tx_state   = TX_IDLE;
			nxt_tx_shifter = WORD_RST;
			nxt_tx_cnt     = BIT_ZERO;
			nxt_tdata      = 1'b0;
			nxt_tfs        = 1'b0;
			nxt_tclk       = 1'b0;
			nxt_tx_irq     = 1'b0;
		end
		if (!reset_n) begin
			nxt_tclk_oe = 1'b0;
			nxt_tfs_oe  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		tx_state_ff   <= nxt_tx_state;
		tx_shifter_ff <= nxt_tx_shifter;
		tx_cnt_ff     <= nxt_tx_cnt;
		tdata_ff      <= nxt_tdata;
		tfs_ff        <= nxt_tfs;
		tclk_ff       <= nxt_tclk;
		tclk_oe_ff    <= nxt_tclk_oe;
		tfs_oe_ff     <= nxt_tfs_oe;
		tx_irq_ff     <= nxt_tx_irq;
		tx_busy_ff    <= nxt_tx_busy;
	end

	assign serial_data_out   = tdata_ff;
	assign tx_bit_clock_out  = tclk_ff;
	assign tx_bit_clock_oe   = tclk_oe_ff;
	assign tx_frame_sync_out = tfs_ff;
	assign tx_frame_sync_oe  = tfs_oe_ff;
	assign tx_queue_irq      = tx_irq_ff;
	assign tx_complete       = tx_busy_ff;

	// Receive side, link clock from the far party
	logic [1:0]        link_meta_ff;
	logic [1:0]        link_sync_ff;
	rx_state_t         rx_state_ff;
	rx_state_t         nxt_rx_state;
	logic [WORD_W-1:0] rx_shifter_ff;
	logic [WORD_W-1:0] nxt_rx_shifter;
	logic [WORD_W-1:0] rx_hold_ff;
	logic [WORD_W-1:0] nxt_rx_hold;
	logic [3:0]        rx_cnt_ff;
	logic [3:0]        nxt_rx_cnt;
	logic              rx_tgl_ff;
	logic              nxt_rx_tgl;
	logic              rx_run;

	// Level crossing of the release and the mode bit into the link domain
	always_ff @(posedge rx_bit_clock) begin
		link_meta_ff <= {continuous_mode, reset_n && rx_reset_n_bit};
		link_sync_ff <= link_meta_ff;
	end
	assign rx_run = link_sync_ff[0];

	always_comb begin
		nxt_rx_state   = rx_state_ff;
		nxt_rx_shifter = {rx_shifter_ff[WORD_W-2:0], serial_data_in};
		nxt_rx_hold    = rx_hold_ff;
		nxt_rx_cnt     = rx_cnt_ff;
		nxt_rx_tgl     = rx_tgl_ff;
		unique case (rx_state_ff)
			RX_IDLE: begin
				if (rx_frame_sync) begin
					nxt_rx_state = RX_SHIFT;
					nxt_rx_cnt   = BIT_ONE;
				end
			end
			RX_SHIFT: begin
				if (rx_cnt_ff == BIT_LAST) begin
					nxt_rx_hold  = nxt_rx_shifter;
					nxt_rx_tgl   = !rx_tgl_ff;
					nxt_rx_cnt   = BIT_ZERO;
					nxt_rx_state = link_sync_ff[1] ? RX_SHIFT : RX_IDLE;
				end else begin
					nxt_rx_cnt = rx_cnt_ff + BIT_ONE;
				end
			end
			default: begin
				nxt_rx_state = RX_IDLE;
			end
		endcase
		if (!rx_run) begin
			nxt_rx_state   = RX_IDLE;
			nxt_rx_shifter = WORD_RST;
			nxt_rx_hold    = WORD_RST;
			nxt_rx_cnt     = BIT_ZERO;
			nxt_rx_tgl     = 1'b0;
		end
	end

	always_ff @(posedge rx_bit_clock) begin
		rx_state_ff   <= nxt_rx_state;
		rx_shifter_ff <= nxt_rx_shifter;
		rx_hold_ff    <= nxt_rx_hold;
		rx_cnt_ff     <= nxt_rx_cnt;
		rx_tgl_ff     <= nxt_rx_tgl;
	end

	// Receive side, cpu clock: word handed over by a toggle
	logic              rx_rst;
	logic              rtgl_meta_ff;
	logic              rtgl_sync_ff;
	logic              rtgl_seen_ff;
	logic              rx_push;
	logic              rx_q_ready;
	logic [LVL_W-1:0]  rx_q_level;
	logic              rx_irq_ff;
	logic              nxt_rx_irq;
	logic              rx_ne_ff;
	logic              nxt_rx_ne;
	logic              rx_ovf_ff;
	logic              nxt_rx_ovf;

	assign rx_rst  = !reset_n || !rx_reset_n_bit;
	// Hold word is stable for many link cycles after each toggle
	assign rx_push = (rtgl_sync_ff != rtgl_seen_ff) && !rx_rst;

	always_ff @(posedge clock) begin
		rtgl_meta_ff <= rx_tgl_ff;
		rtgl_sync_ff <= rtgl_meta_ff;
		rtgl_seen_ff <= rtgl_sync_ff;
	end

	sync_queue #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) u_rx_queue (
		.clock     (clock),
		.reset_n   (reset_n),
		.clear     (rx_rst),
		.in_valid  (rx_push),
		.in_data   (rx_hold_ff),
		.in_ready  (rx_q_ready),
		.out_valid (rx_valid),
		.out_data  (rx_word),
		.out_ready (rx_ready),
		.level     (rx_q_level)
	);

	always_comb begin
		nxt_rx_irq = reaches(rx_q_level, rx_irq_level);
		nxt_rx_ne  = (rx_q_level != '0);
		// A word arriving at a full queue is lost and flagged
		nxt_rx_ovf = rx_ovf_ff || (rx_push && !rx_q_ready);
		if (rx_rst) begin
			nxt_rx_irq = 1'b0;
			nxt_rx_ne  = 1'b0;
			nxt_rx_ovf = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		rx_irq_ff <= nxt_rx_irq;
		rx_ne_ff  <= nxt_rx_ne;
		rx_ovf_ff <= nxt_rx_ovf;
	end

	assign rx_queue_irq = rx_irq_ff;
	assign rx_not_empty = rx_ne_ff;
	assign rx_overflow  = rx_ovf_ff;

	sequence s_last_bit;
		tx_tick && (tx_state_ff == TX_SHIFT) && (tx_cnt_ff == BIT_ZERO);
	endsequence
	sequence s_new_word;
		(tx_state_ff == TX_SHIFT) && (tx_cnt_ff == BIT_LAST);
	endsequence

	a_tx_half_rate: assert property (@(posedge clock) disable iff (tx_rst)
		(tx_clock_internal && $past(tx_clock_internal) && !$past(tx_rst))
		|-> (tx_bit_clock_out != $past(tx_bit_clock_out)))
		else $error("internal bit clock not at half rate");
	a_tclk_dir: assert property (@(posedge clock) disable iff (!reset_n)
		$past(reset_n) |-> (tx_bit_clock_oe == $past(tx_clock_internal)))
		else $error("bit clock enable does not follow selection");
	a_tfs_pulse: assert property (@(posedge clock) disable iff (tx_rst)
		(tx_start && tx_fsync_internal && tx_clock_internal)
		|=> tx_frame_sync_out[*2] ##1 !tx_frame_sync_out)
		else $error("internal frame sync missing at word start");
	a_msb_first: assert property (@(posedge clock) disable iff (tx_rst)
		tx_load |=> (serial_data_out == $past(tx_q_msb)))
		else $error("first bit out is not the msb");
	a_burst_stop: assert property (@(posedge clock) disable iff (tx_rst)
		(s_last_bit ##0 !continuous_mode) |=> (tx_state_ff == TX_IDLE))
		else $error("burst word did not stop after 16 bits");
	a_cont_chain: assert property (@(posedge clock) disable iff (tx_rst)
		(s_last_bit ##0 (continuous_mode && tx_q_valid)) |=> s_new_word)
		else $error("continuous word not sent back to back");
	a_fifo_load: assert property (@(posedge clock) disable iff (tx_rst)
		(tx_tick && (tx_state_ff == TX_IDLE) && tx_q_valid && fs_ok)
		|-> tx_load ##1 s_new_word)
		else $error("empty shifter not loaded from queue");
	a_tx_idle: assert property (@(posedge clock) disable iff (tx_rst)
		(tx_state_ff == TX_IDLE) |-> (!serial_data_out && !tx_frame_sync_out))
		else $error("output not idle while shifter empty");
	a_rx_irq_full: assert property (@(posedge clock) disable iff (rx_rst)
		(rx_q_level == LVL_FULL) |=> rx_queue_irq)
		else $error("full receive queue raised no interrupt");
	a_rx_cross: assert property (@(posedge clock) disable iff (rx_rst)
		(rx_push && rx_q_ready && !(rx_valid && rx_ready))
		|=> (rx_q_level == $past(rx_q_level) + 3'h1))
		else $error("received word lost in crossing");
	a_rx_start: assert property (@(posedge rx_bit_clock) disable iff (!rx_run)
		(rx_run && (rx_state_ff == RX_IDLE) && rx_frame_sync)
		|=> ((rx_state_ff == RX_SHIFT) && (rx_cnt_ff == BIT_ONE)))
		else $error("receive sync did not start a word");
	a_rx_word: assert property (@(posedge rx_bit_clock) disable iff (!rx_run)
		(rx_run && (rx_state_ff == RX_SHIFT) && (rx_cnt_ff == BIT_LAST))
		|=> ((rx_hold_ff[0] == $past(serial_data_in)) && $changed(rx_tgl_ff)))
		else $error("received word not completed after 16 bits");
endmodule // sync_serial_port

`default_nettype wire

/* tb_sync_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_port;
	import sync_serial_pkg::*;
	logic              clock = 1'b0;
	logic              reset_n, tx_reset_n_bit, rx_reset_n_bit;
	logic              tx_clock_internal, tx_fsync_internal, continuous_mode;
	logic [1:0]        tx_irq_level, rx_irq_level;
	logic [WORD_W-1:0] tx_word, rx_word, cap_word;
	logic              tx_valid, tx_ready, rx_valid, rx_ready, rdy_s;
	logic              tx_queue_irq, rx_queue_irq, tx_complete, rx_not_empty;
	logic              rx_overflow, clk_out, clk_oe, fs_out, fs_oe, sdo;
	logic              rx_clk, rx_fs, sdi, cap_stb;
	wire logic         clk_pin, fs_pin;
	logic [31:0]       rnd, pin_rnd;
	logic [15:0]       txq[$], rxq[$];
	int                error_cnt = 0, num_checks = 0, cyc = 0;
	time               t0;

	always #5 clock = ~clock;
	assign clk_pin = clk_oe ? clk_out : pin_rnd[3];
	assign fs_pin  = fs_oe ? fs_out : pin_rnd[9];

	sync_serial_port DUT (.clock(clock), .reset_n(reset_n),
		.tx_reset_n_bit(tx_reset_n_bit), .rx_reset_n_bit(rx_reset_n_bit),
		.tx_clock_internal(tx_clock_internal),
		.tx_fsync_internal(tx_fsync_internal),
		.continuous_mode(continuous_mode), .tx_irq_level(tx_irq_level),
		.rx_irq_level(rx_irq_level), .tx_word(tx_word), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_queue_irq(tx_queue_irq),
		.rx_queue_irq(rx_queue_irq), .tx_complete(tx_complete),
		.rx_not_empty(rx_not_empty), .rx_overflow(rx_overflow),
		.tx_bit_clock_in(clk_pin), .tx_bit_clock_out(clk_out),
		.tx_bit_clock_oe(clk_oe), .tx_frame_sync_in(fs_pin),
		.tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe),
		.serial_data_out(sdo), .rx_bit_clock(rx_clk),
		.rx_frame_sync(rx_fs), .serial_data_in(sdi));

	far_codec far (.tx_clk(clk_pin), .tx_fs(fs_pin), .tx_data(sdo),
		.continuous(continuous_mode), .cap_stb(cap_stb),
		.cap_word(cap_word), .rx_clk(rx_clk), .rx_fs(rx_fs), .rx_data(sdi));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Holds valid up between words; caller lowers it after the last one
	task automatic push(input logic [15:0] w);
		txq.push_back(w);
		tx_word <= w;
		tx_valid <= 1'b1;
		do @(posedge clock); while (rdy_s !== 1'b1);
	endtask

	task automatic push_n(input int n);
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			push(rnd[15:0]);
		end
		tx_valid <= 1'b0;
	endtask

	task automatic drain_tx();
		for (int k = 0; k < 900 && (tx_complete !== 1'b0 || txq.size() != 0); k++)
			@(posedge clock);
		repeat (60) @(posedge clock);
		@(negedge clock);
		check(txq.size(), 0);
		check(sdo, 1'b0);
		@(posedge clock);
	endtask

	task automatic rx_reset();
		rx_reset_n_bit <= 1'b0;
		far.line_idle(4);
		@(posedge clock);
		rx_reset_n_bit <= 1'b1;
		// Link side only sees the release after two of its own edges
		far.line_idle(2);
	endtask

	always @(posedge clock) begin
		pin_rnd <= lfsr(pin_rnd);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// Transmitted words, oldest note first; idle zeros allowed only when none due
	always @(cap_stb) begin
		if (txq.size() > 0)
			check(cap_word, txq.pop_front());
		else
			check(cap_word, 16'h0000);
	end

	always @(negedge clock) begin
		rdy_s = tx_ready;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check(rx_word, rxq.size() ? rxq.pop_front() : 16'hdead);
	end

	initial begin
		reset_n = 1'b0;
		tx_reset_n_bit = 1'b0;
		rx_reset_n_bit = 1'b0;
		tx_clock_internal = 1'b1;
		tx_fsync_internal = 1'b1;
		continuous_mode = 1'b0;
		tx_irq_level = 2'h3;
		rx_irq_level = 2'h3;
		tx_word = 16'h0000;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		rnd = 32'h2f64ecbe;
		pin_rnd = 32'h2f64ecbe;
		fork
			far.line_idle(4);
			begin
				repeat (6) @(posedge clock);
				reset_n <= 1'b1;
			end
		join
		@(posedge clock);
		tx_reset_n_bit <= 1'b1;
		rx_reset_n_bit <= 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check(tx_ready, 1'b1);
		check({clk_oe, fs_oe}, 2'h3);
		check(tx_queue_irq, 1'b1);
		@(posedge clock);
		tx_clock_internal <= 1'b0;
		tx_fsync_internal <= 1'b0;
		repeat (3) @(negedge clock);
		check({clk_oe, fs_oe}, 2'h0);
		@(posedge clock);
		tx_clock_internal <= 1'b1;
		tx_fsync_internal <= 1'b1;
		@(posedge clk_out);
		t0 = $time;
		@(posedge clk_out);
		check(32'($time - t0), 32'd20);
		$display("test pins done");

		@(posedge clock);
		push_n(5);
		repeat (2) @(negedge clock);
		check({tx_ready, tx_complete, tx_queue_irq}, 3'h2);
		drain_tx();
		$display("test burst tx done");

		continuous_mode <= 1'b1;
		push_n(3);
		drain_tx();
		continuous_mode <= 1'b0;
		$display("test continuous tx done");
		far.line_idle(2);

		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			if (i < 4)
				rxq.push_back(rnd[15:0]);
			far.send_word(rnd[15:0], 1'b1);
			far.line_idle(0);
			repeat (3) @(posedge clock);
		end
		repeat (8) @(negedge clock);
		check({rx_overflow, rx_queue_irq, rx_not_empty}, 3'h7);
		@(posedge clock);
		rx_ready <= 1'b1;
		repeat (12) @(negedge clock);
		check({rxq.size() != 0, rx_valid, rx_not_empty, rx_queue_irq},
			4'h0);
		$display("test rx overflow done");
		@(posedge clock);
		continuous_mode <= 1'b1;

		rnd = lfsr(rnd);
		rxq.push_back(rnd[15:0]);
		rxq.push_back(~rnd[15:0]);
		far.send_word(rnd[15:0], 1'b1);
		far.send_word(~rnd[15:0], 1'b0);
		far.line_idle(0);
		repeat (12) @(negedge clock);
		check(rxq.size(), 0);
		@(posedge clock);
		rx_reset();
		tx_reset_n_bit <= 1'b0;
		repeat (2) @(negedge clock);
		check({rx_overflow, tx_ready}, 2'h0);
		$display("test rx continuous and resets done");
		end_of_test();
	end
endmodule // tb_sync_serial_port
`default_nettype wire
